// file: inc/smf_pkg.sv
// Purpose: shared types and constants of the multi-format serial port
// Assumes: word length is coded as bit count minus one, legal range 3..15
// Notes: frame-sync, four-wire select and control-word formats share one shifter
package smf_pkg;
	localparam int WORD_W = 16;
	localparam logic [3:0] LEN_MIN = 4'h3;
	localparam logic [3:0] LEN_TOP = 4'hf;
	localparam logic [4:0] CW_CTRL_BITS = 5'h08;
	localparam logic [4:0] CW_WAIT_BITS = 5'h01;
	localparam logic [4:0] ONE_BIT = 5'h01;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [7:0] CW_PAD = 8'h00;

	typedef enum logic [1:0] {
		SMF_FMT_FRAME,
		SMF_FMT_SPI,
		SMF_FMT_CW
	} smf_fmt_t;

	typedef enum logic [2:0] {
		SMF_IDLE,
		SMF_SYNC,
		SMF_LEAD,
		SMF_SHIFT,
		SMF_TAIL
	} smf_state_t;

	typedef struct packed {
		logic [WORD_W-1:0] data;
		smf_fmt_t fmt;
		logic cpol;
		logic cpha;
		logic [3:0] len;
	} smf_word_t;
endpackage

// file: core/smf_serial_port.sv
// Purpose: frame-level serializer of a synchronous serial port master
// Assumes: link_clk period is half a bit-clock period; cfg steady while busy
// Notes: words cross by toggle handshake; pins are driven from link_clk flops
`timescale 1ns/1ps

// Overview of operation
// R1 - frame-sync format idle: clock and sync low, transmit line released
// R2 - frame-sync format: word loaded, sync pulsed high one bit period
// R3 - frame-sync format: MSB leaves on next rising edge, frames 4 to 16 bits
// R4 - frame-sync format: both ends sample incoming bits on falling edges
// R5 - frame-sync format: received word pushed at first rising edge after LSB
// R6 - SPI idle clock level equals clock polarity; the port idles at the polarity latched with the last word, low after reset
// R7 - phase zero captures on first transition, phase one on second
// R8 - SPI idle: select high, data pad released
// R9 - enabled with word waiting: select driven low and data driver enabled
// R10 - phase zero: data half period after select falls, edge half later
// R11 - rising capture when polarity equals phase, falling capture otherwise
// R12 - phase one: data and first edge half period after select falls
// R13 - select returns high one clock period after final capture
// R14 - phase zero back-to-back: select pulsed high between words
// R15 - phase one back-to-back: select stays low until last word ends
// R16 - control-word frame: 8 control bits, one wait clock, 4-16 reply bits
// R17 - control-word idle: clock low, select high, data output low
// R18 - control-word: select falls, control MSB driven, select held for frame
// R19 - control-word: reply bits latched by the port on rising edges
// R20 - single control-word frame: select rises one period after last reply bit
// R21 - continuous control-word: next control byte follows reply LSB directly
// R22 - slave control-word: first bit on first rising clock after select low
// R23 - frame-sync and SPI move exactly the configured length, MSB first
module smf_serial_port
	import smf_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic enable,
	input wire smf_fmt_t fmt,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [3:0] word_len,
	input wire logic slave_mode,
	input wire logic tx_valid,
	input wire logic [WORD_W-1:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [WORD_W-1:0] rx_data,
	output logic busy,
	output logic ser_clk,
	output logic sel_n,
	output logic frame_sync_out,
	output logic ser_tx,
	output logic ser_tx_oe,
	input wire logic ser_rx,
	input wire logic slv_clk,
	input wire logic slv_sel_n
);
	smf_word_t hold;
	logic req;
	logic ack;
	logic ack_a;
	logic ack_s;
	logic rtg_a;
	logic rtg_s;
	logic rtg_d;
	logic busy_a;
	logic rx_tgl;
	logic [WORD_W-1:0] rx_word;

	logic lrst_a;
	logic lrst_n;
	logic req_a;
	logic req_s;
	logic rx_a;
	logic rx_s;
	logic sclk_a;
	logic sclk_s;
	logic sclk_d;
	logic ssel_a;
	logic ssel_s;
	logic ssel_d;
	logic smode_a;
	logic slv_on;
	smf_state_t st;
	smf_fmt_t lfmt;
	logic lpol;
	logic lpha;
	logic [3:0] llen;
	logic [3:0] push_len;
	logic [4:0] bc;
	logic hc;
	logic lbusy;
	logic [WORD_W-1:0] tx_sr;
	logic [WORD_W-1:0] rx_sr;
	logic [WORD_W-1:0] srx;
	logic [1:0] cap_p;
	logic [1:0] last_p;

	logic pending;
	logic lead;
	logic launch;
	logic capture;
	logic last;
	logic cont;
	logic slv_cap;
	logic slv_end;
	logic [WORD_W-1:0] ta;
	logic [WORD_W-1:0] rx_next;

	function automatic logic [4:0] frame_bits(input smf_word_t w);
		if (w.fmt == SMF_FMT_CW)
			frame_bits = 5'(w.len) + CW_CTRL_BITS + CW_WAIT_BITS + ONE_BIT; // R16
		else
			frame_bits = 5'(w.len) + ONE_BIT; // R23
	endfunction

	// left-justify so the MSB always leaves from bit 15
	function automatic logic [WORD_W-1:0] tx_align(input smf_word_t w);
		if (w.fmt == SMF_FMT_CW)
			tx_align = {w.data[7:0], CW_PAD};
		else
			tx_align = w.data << (LEN_TOP - w.len); // R23
	endfunction

	function automatic logic [WORD_W-1:0] len_mask(input logic [3:0] len);
		len_mask = {WORD_W{1'b1}} >> (LEN_TOP - len);
	endfunction

	// ---------------- mclk side ----------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_a <= 1'b0;
			ack_s <= 1'b0;
			rtg_a <= 1'b0;
			rtg_s <= 1'b0;
			rtg_d <= 1'b0;
			busy_a <= 1'b0;
			busy <= 1'b0;
		end else begin
			ack_a <= ack;
			ack_s <= ack_a;
			rtg_a <= rx_tgl;
			rtg_s <= rtg_a;
			rtg_d <= rtg_s;
			busy_a <= lbusy;
			busy <= busy_a;
		end
	end

	// hold stays untouched until the link returns the toggle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold <= '0;
			req <= 1'b0;
			tx_ready <= 1'b1;
		end else if (tx_valid && tx_ready && enable) begin // R9
			hold.data <= tx_data;
			hold.fmt <= fmt;
			hold.cpol <= cpol;
			hold.cpha <= cpha;
			hold.len <= (word_len < LEN_MIN) ? LEN_MIN : word_len;
			req <= ~req;
			tx_ready <= 1'b0;
		end else if (ack_s == req) begin
			tx_ready <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_valid <= 1'b0;
			rx_data <= WORD_RST;
		end else begin
			rx_valid <= rtg_s ^ rtg_d;
			if (rtg_s ^ rtg_d)
				rx_data <= rx_word;
		end
	end

	// ---------------- link side ----------------
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lrst_a <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst_a <= 1'b1;
			lrst_n <= lrst_a;
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			req_a <= 1'b0;
			req_s <= 1'b0;
			rx_a <= 1'b0;
			rx_s <= 1'b0;
			sclk_a <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			ssel_a <= 1'b1;
			ssel_s <= 1'b1;
			ssel_d <= 1'b1;
			smode_a <= 1'b0;
			slv_on <= 1'b0;
		end else begin
			req_a <= req;
			req_s <= req_a;
			rx_a <= ser_rx;
			rx_s <= rx_a;
			sclk_a <= slv_clk;
			sclk_s <= sclk_a;
			sclk_d <= sclk_s;
			ssel_a <= slv_sel_n;
			ssel_s <= ssel_a;
			ssel_d <= ssel_s;
			smode_a <= slave_mode;
			slv_on <= smode_a;
		end
	end

	assign ta = tx_align(hold);
	assign pending = (req_s != ack) && !slv_on;
	assign lead = (ser_clk == lpol);
	assign launch = lpha ? lead : !lead; // R11
	assign capture = !launch; // R7
	assign last = capture && (bc == ONE_BIT);
	assign cont = pending && (hold.fmt == lfmt) && (hold.cpol == lpol) && (hold.cpha == lpha)
		&& ((lfmt == SMF_FMT_CW) || ((lfmt == SMF_FMT_SPI) && lpha));
	assign slv_cap = slv_on && !ssel_s && sclk_s && !sclk_d;
	assign slv_end = slv_on && ssel_s && !ssel_d;
	assign rx_next = {rx_sr[WORD_W-2:0], rx_s};

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			st <= SMF_IDLE;
			lfmt <= SMF_FMT_SPI;
			lpol <= 1'b0;
			lpha <= 1'b0;
			llen <= LEN_MIN;
			ack <= 1'b0;
			bc <= '0;
			hc <= 1'b0;
			tx_sr <= WORD_RST;
			ser_clk <= 1'b0;
			sel_n <= 1'b1;
			frame_sync_out <= 1'b0;
			ser_tx <= 1'b0;
			ser_tx_oe <= 1'b0;
		end else begin
			unique case (st)
				SMF_IDLE: begin
					ser_clk <= (lfmt == SMF_FMT_SPI) ? lpol : 1'b0; // R1 R6 R17
					sel_n <= 1'b1; // R8 R14
					frame_sync_out <= 1'b0; // R1
					ser_tx <= 1'b0; // R17
					ser_tx_oe <= (lfmt == SMF_FMT_CW); // R1 R8
					if (pending) begin
						lfmt <= hold.fmt;
						llen <= hold.len;
						bc <= frame_bits(hold);
						ack <= ~ack;
						tx_sr <= ta;
						ser_tx_oe <= 1'b1; // R9
						hc <= 1'b0;
						unique case (hold.fmt)
							SMF_FMT_FRAME: begin
								lpol <= 1'b0;
								lpha <= 1'b1; // R4
								ser_clk <= 1'b0;
								frame_sync_out <= 1'b1; // R2
								st <= SMF_SYNC;
							end
							SMF_FMT_SPI: begin
								lpol <= hold.cpol;
								lpha <= hold.cpha;
								ser_clk <= hold.cpol;
								sel_n <= 1'b0; // R9
								st <= hold.cpha ? SMF_SHIFT : SMF_LEAD; // R12
							end
							SMF_FMT_CW: begin
								lpol <= 1'b0;
								lpha <= 1'b0;
								ser_clk <= 1'b0;
								sel_n <= 1'b0; // R18
								ser_tx <= ta[WORD_W-1]; // R18
								tx_sr <= ta << 1;
								st <= SMF_SHIFT;
							end
						endcase
					end
				end
				// one full bit period of sync with the clock running
				SMF_SYNC: begin
					hc <= ~hc;
					ser_clk <= ~ser_clk;
					if (hc) begin
						frame_sync_out <= 1'b0; // R2
						st <= SMF_SHIFT;
					end
				end
				SMF_LEAD: begin
					ser_tx <= tx_sr[WORD_W-1]; // R10
					tx_sr <= tx_sr << 1;
					st <= SMF_SHIFT;
				end
				SMF_SHIFT: begin
					ser_clk <= ~ser_clk; // R10 R12
					if (launch) begin
						ser_tx <= tx_sr[WORD_W-1]; // R3 R11
						tx_sr <= tx_sr << 1;
					end
					if (capture) begin
						bc <= bc - ONE_BIT;
						if (last) begin
							hc <= 1'b0;
							if (cont) begin
								llen <= hold.len; // R15 R21
								bc <= frame_bits(hold);
								tx_sr <= ta;
								ack <= ~ack;
							end else begin
								st <= SMF_TAIL;
							end
						end
					end
				end
				// second half lands exactly one period after the last capture
				SMF_TAIL: begin
					hc <= 1'b1;
					ser_clk <= (lfmt == SMF_FMT_FRAME && !hc) ? 1'b1 : lpol; // R5
					if (hc) begin
						sel_n <= 1'b1; // R13 R20
						ser_tx <= 1'b0;
						ser_tx_oe <= (lfmt == SMF_FMT_CW);
						st <= SMF_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n)
			lbusy <= 1'b0;
		else
			lbusy <= (st != SMF_IDLE) || pending;
	end

	// the data pin is synchronised, so a capture lands two cycles late
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			cap_p <= 2'h0;
			last_p <= 2'h0;
			push_len <= LEN_MIN;
			rx_sr <= WORD_RST;
			srx <= WORD_RST;
			rx_word <= WORD_RST;
			rx_tgl <= 1'b0;
		end else begin
			cap_p <= {cap_p[0], (st == SMF_SHIFT) && capture};
			last_p <= {last_p[0], (st == SMF_SHIFT) && last};
			if ((st == SMF_SHIFT) && last)
				push_len <= llen;
			if (cap_p[1])
				rx_sr <= rx_next; // R4 R7 R11 R19
			if (slv_cap)
				srx <= {srx[WORD_W-2:0], rx_s}; // R22
			if (last_p[1]) begin
				rx_word <= rx_next & len_mask(push_len); // R5 R20 R21 R23
				rx_tgl <= ~rx_tgl;
			end else if (slv_end) begin
				rx_word <= srx;
				rx_tgl <= ~rx_tgl;
			end
		end
	end
endmodule // smf_serial_port

// file: dv/smf_monitor.sv
// Purpose: pin-level checker for the multi-format serial port
// Assumes: configuration held steady while a word is in flight
// Notes: user-side timing is judged by the bench
`timescale 1ns/1ps
module smf_monitor
	import smf_pkg::*;
(
	input wire logic link_clk,
	input wire logic rst_n,
	input wire smf_fmt_t fmt,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic ser_clk,
	input wire logic sel_n,
	input wire logic frame_sync_out,
	input wire logic ser_tx_oe
);
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!rst_n);

	a_sync_pulse:
	assert property ($rose(frame_sync_out) |-> !ser_clk ##1 (frame_sync_out && ser_clk)
		##1 !(frame_sync_out || ser_clk) ##1 ser_clk) else $error("sync pulse shape wrong");
	a_sync_drive:
	assert property ($rose(frame_sync_out) |-> ser_tx_oe) else $error("sync without driver");
	a_sync_no_sel:
	assert property (frame_sync_out |-> sel_n) else $error("select low in sync format");
	a_sel_drive:
	assert property ($fell(sel_n) |-> ser_tx_oe) else $error("select low, driver off");
	a_lead_half:
	assert property ($fell(sel_n) && fmt == SMF_FMT_SPI && !cpha |=> $stable(ser_clk)
		##1 $changed(ser_clk)) else $error("phase zero first edge misplaced");
	a_lead_now:
	assert property ($fell(sel_n) && (fmt == SMF_FMT_CW || cpha) |=> $changed(ser_clk))
		else $error("first edge late");
	a_sel_end_idle:
	assert property ($rose(sel_n) |-> $stable(ser_clk) && ser_clk == (fmt == SMF_FMT_SPI && cpol))
		else $error("clock not idle at select release");
	a_idle_clk_still:
	assert property ((sel_n && !ser_tx_oe) [*2] |-> $stable(ser_clk))
		else $error("clock moves while idle");
endmodule // smf_monitor

// file: dv/smf_slave_model.sv
// Purpose: behavioural four-wire slave for the serial port bench
// Assumes: mode and word length steady during a frame
// Notes: only four-wire framing is modelled
`timescale 1ns/1ps
module smf_slave_model (
	input wire logic ser_clk,
	input wire logic sel_n,
	input wire logic ser_tx,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [3:0] len,
	input wire logic [15:0] reply,
	output logic ser_rx,
	output logic [15:0] got
);
	wire sel_q;
	int i;
	// delayed select hides a clock step made while select falls
	assign #1 sel_q = sel_n;
	initial ser_rx = 1'b0;
	always @(negedge sel_n) begin
		i = cpha ? len + 1 : len;
		ser_rx = cpha ? ~ser_rx : reply[i];
		got = 16'h0000;
	end
	always @(ser_clk) begin
		if (!sel_q && ser_clk == (cpol ^ cpha)) begin
			if (i == 0)
				i = len + 1;
			i = i - 1;
			ser_rx = reply[i];
		end else if (!sel_q) begin
			got = {got[14:0], ser_tx};
		end
	end
	// released line shows the opposite of its last bit
	always @(posedge sel_n) ser_rx = ~ser_rx;
endmodule // smf_slave_model

// file: dv/tb_smf_serial_port.sv
// Purpose: self-checking bench for the multi-format serial port
// Assumes: configuration held steady while a word is in flight
// Notes: slave-mode inputs stay idle except in the slave scenario, which drives them
`timescale 1ns/1ps
module tb_smf_serial_port;
	import smf_pkg::*;
	logic mclk = 0, link_clk = 0, rst_n = 0, enable = 0, cpol = 0, cpha = 0, tx_valid = 0;
	smf_fmt_t fmt = SMF_FMT_SPI;
	logic [3:0] len = 4'h7;
	logic [15:0] tx_data = 16'h0000, reply = 16'h0000, got, rx_data;
	logic tx_ready, rx_valid, busy, ser_clk, sel_n, frame_sync_out, ser_tx, ser_tx_oe, ser_rx;
	logic slave_mode = 0, slv_clk = 0, slv_sel_n = 1, sdat = 0, mdl_rx;
	int err_count = 0, n_checks = 0, sel_ups = 0, sync_ups = 0, clk_ups = 0;
	always #5 mclk = ~mclk;
	always #6 link_clk = ~link_clk;
	// slave scenario drives the data pin itself, the four-wire model otherwise
	assign ser_rx = slave_mode ? sdat : mdl_rx;
	always @(posedge sel_n) sel_ups++;
	always @(posedge frame_sync_out) sync_ups++;
	always @(posedge ser_clk) clk_ups++;
	smf_serial_port u_dut (.mclk, .rst_n, .link_clk, .enable, .fmt, .cpol, .cpha,
		.word_len(len), .slave_mode, .tx_valid, .tx_data, .tx_ready, .rx_valid,
		.rx_data, .busy, .ser_clk, .sel_n, .frame_sync_out, .ser_tx, .ser_tx_oe,
		.ser_rx, .slv_clk, .slv_sel_n);
	smf_slave_model u_slave (.ser_clk, .sel_n, .ser_tx, .cpol, .cpha, .len, .reply,
		.ser_rx(mdl_rx), .got);
	task automatic chk(input string what, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic until_high(ref logic sig);
		int n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (sig !== 1'b1 && n < 3000);
		if (n == 3000) begin
			err_count++;
			final_report();
		end
	endtask
	task automatic send(input logic [15:0] d);
		until_high(tx_ready);
		tx_data = d;
		tx_valid = 1;
		@(posedge mclk);
		#1 tx_valid = 0;
	endtask
	task automatic t_off();
		tx_valid = 1;
		repeat (5) @(posedge mclk);
		#1 chk("ready_off", 16'({sel_n, tx_ready, ser_tx_oe, busy}), 16'h000c);
		tx_valid = 0;
		enable = 1;
	endtask
	task automatic t_spi();
		logic [15:0] mask;
		for (int m = 0; m < 4; m++) begin
			{cpol, cpha} = m[1:0];
			len = m[0] ? 4'hf : 4'h3;
			mask = 16'hffff >> (4'hf - len);
			reply = 16'h9c5a ^ 16'(m);
			clk_ups = 0;
			send(16'ha5c3 + 16'(m));
			until_high(rx_valid);
			chk("rx_data", rx_data, reply & mask);
			chk("mosi", got, (16'ha5c3 + 16'(m)) & mask);
			chk("clk_rises", 16'(clk_ups), 16'(len) + 16'h0001 + 16'(m == 2));
		end
	endtask
	task automatic t_b2b();
		cpol = 0;
		len = 4'h7;
		reply = 16'h003c;
		for (int p = 0; p < 2; p++) begin
			cpha = p[0];
			sel_ups = 0;
			send(16'h0081);
			send(16'h0042);
			until_high(rx_valid);
			chk("rx_first", rx_data, 16'h003c);
			until_high(rx_valid);
			chk("rx_second", rx_data, 16'h003c);
			chk("sel_rises", 16'(sel_ups), 16'(2 - p));
		end
	endtask
	task automatic t_fs();
		fmt = SMF_FMT_FRAME;
		len = 4'h4;
		sync_ups = 0;
		sel_ups = 0;
		send(16'h0015);
		until_high(rx_valid);
		chk("sync_pulses", 16'(sync_ups), 16'h0001);
		chk("fs_sel", 16'(sel_ups), 16'h0000);
	endtask
	task automatic t_cw();
		fmt = SMF_FMT_CW;
		len = 4'h3;
		clk_ups = 0;
		send(16'h00a6);
		repeat (10) @(posedge mclk);
		#1 chk("cw_busy", 16'(busy), 16'h0001);
		until_high(rx_valid);
		chk("cw_rises", 16'(clk_ups), 16'h000d);
		chk("cw_idle", 16'({ser_clk, sel_n, ser_tx}), 16'h0002);
		repeat (3) @(posedge mclk);
		#1 chk("cw_busy_end", 16'(busy), 16'h0000);
	endtask
	// slow select and clock so the port's synchronisers see every level
	task automatic t_slv();
		logic [15:0] w;
		w = 16'h6d2b;
		slave_mode = 1;
		repeat (4) @(posedge mclk);
		#1 slv_sel_n = 0;
		for (int b = 15; b >= 0; b--) begin
			sdat = w[b];
			repeat (4) @(posedge mclk);
			#1 slv_clk = 1;
			repeat (4) @(posedge mclk);
			#1 slv_clk = 0;
		end
		slv_sel_n = 1;
		until_high(rx_valid);
		chk("slv_rx", rx_data, 16'h6d2b);
		slave_mode = 0;
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		#1 rst_n = 1;
		t_off();
		t_spi();
		t_b2b();
		t_fs();
		t_cw();
		t_slv();
		final_report();
	end
endmodule // tb_smf_serial_port
bind smf_serial_port smf_monitor u_mon (.link_clk, .rst_n, .fmt, .cpol, .cpha, .ser_clk,
	.sel_n, .frame_sync_out, .ser_tx_oe);
